// ===== intc_pkg.sv
// shared constants, types and helpers of the vectored interrupt controller
package intc_pkg;
   // ==========================================================
   // geometry
   localparam int NUM_SLOTS = 17;
   localparam int NUM_PINS = 8;
   // ==========================================================
   // vector addresses
   localparam logic [15:0] VEC_BASE = 16'h0004;
   localparam logic [15:0] VEC_BREAK = 16'h003e;
   localparam logic [15:0] VEC_RESET = 16'h0000;
   // ==========================================================
   // default priority slots, 0 is the strongest
   localparam int SLOT_LVI = 0;
   localparam int SLOT_PIN0 = 1;
   localparam int SLOT_TM2A = 3;
   localparam int SLOT_TM2B = 4;
   localparam int SLOT_TM3A = 5;
   localparam int SLOT_TM3B = 6;
   localparam int SLOT_CAN_ERR = 7;
   localparam int SLOT_CAN_WAKE = 8;
   localparam int SLOT_CAN_RX = 9;
   localparam int SLOT_CAN_TX = 10;
   localparam int SLOT_SER_A_RXERR = 11;
   localparam int SLOT_SER_A_RXEND = 12;
   localparam int SLOT_SER_A_TXEND = 13;
   localparam int SLOT_CSI = 14;
   localparam int SLOT_SER_B_RXERR = 14;
   localparam int SLOT_PIN6 = 15;
   localparam int SLOT_SER_B_RXEND = 15;
   localparam int SLOT_PIN7 = 16;
   localparam int SLOT_SER_B_TXEND = 16;
   // ==========================================================
   // register byte offsets
   localparam logic [5:0] REG_FLAGS = 6'h00;
   localparam logic [5:0] REG_MASK = 6'h04;
   localparam logic [5:0] REG_PRIO = 6'h08;
   localparam logic [5:0] REG_CTRL = 6'h0c;
   localparam logic [5:0] REG_STATUS = 6'h10;
   localparam logic [5:0] REG_CAUSE = 6'h14;
   localparam logic [5:0] REG_PIN_RISE = 6'h18;
   localparam logic [5:0] REG_PIN_FALL = 6'h1c;
   // ==========================================================
   // field positions and reset values
   localparam int CTRL_IE = 0;
   localparam int STAT_ISV_LO = 0;
   localparam int STAT_ISV_HI = 1;
   localparam int STAT_REQ = 2;
   localparam int STAT_SWI = 3;
   localparam int STAT_VEC_LSB = 16;
   localparam logic [16:0] MASK_RST = 17'h1ffff;
   localparam logic [16:0] PRIO_RST = 17'h1ffff;
   localparam logic [7:0] RISE_RST = 8'hff;
   localparam logic [7:0] FALL_RST = 8'h00;
   // ==========================================================
   // types
   typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;
   // ==========================================================
   // helpers
   // lowest set index with a found bit on top
   function automatic logic [5:0] first_set(input logic [16:0] v);
      logic [5:0] r;
      r = 6'h00;
      for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 5'(i)};
         end
      end
      return r;
   endfunction
   // vector address of a slot, two bytes apart
   function automatic logic [15:0] vector_of(input logic [4:0] slot);
      return VEC_BASE + {10'h000, slot, 1'b0};
   endfunction
   // byte enables spread to a bit mask
   function automatic logic [31:0] be_mask(input logic [3:0] be);
      return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction
endpackage

// ===== pin_edge_if.sv
// edge selection and detected pin edges between controller and detector
`timescale 1ns/1ns
interface pin_edge_if;
   logic [7:0] rise_en;
   logic [7:0] fall_en;
   logic [7:0] edge_hit;
   modport detector (input rise_en, input fall_en, output edge_hit);
   modport ctrl (output rise_en, output fall_en, input edge_hit);
endinterface

// ===== pin_edge_detect.sv
// synchroniser and edge detector for the external interrupt pins
`timescale 1ns/1ns
module pin_edge_detect (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [7:0] pin_in,
   pin_edge_if.detector port
);
   logic [7:0] meta_ff, nxt_meta;
   logic [7:0] sync_ff, nxt_sync;
   logic [7:0] last_ff, nxt_last;
   // ==========================================================
   // two stage sync then previous level
   always_comb begin
      nxt_meta = pin_in;
      nxt_sync = meta_ff;
      nxt_last = sync_ff;
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= 8'h00;
         sync_ff <= 8'h00;
         last_ff <= 8'h00;
      end else if (clk_en) begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
         last_ff <= nxt_last;
      end
   end
   // selected edges only, one cycle each
   assign port.edge_hit = (sync_ff & ~last_ff & port.rise_en) |
      (~sync_ff & last_ff & port.fall_en);
endmodule // pin_edge_detect

// ===== vectored_interrupt_priority.sv
// vectored two level interrupt controller with avalon register slave
`timescale 1ns/1ns
module vectored_interrupt_priority import intc_pkg::*; (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic irq_low_voltage,
   input wire logic [7:0] ext_pin_in,
   input wire logic irq_can_error,
   input wire logic irq_can_wakeup,
   input wire logic irq_can_receive,
   input wire logic irq_can_transmit,
   input wire logic irq_serial_a_rx_error,
   input wire logic irq_serial_a_rx_end,
   input wire logic irq_serial_a_tx_end,
   input wire logic irq_clocked_serial_end,
   input wire logic irq_serial_b_rx_error,
   input wire logic irq_serial_b_rx_end,
   input wire logic irq_serial_b_tx_end,
   input wire logic irq_timer2_match_a,
   input wire logic irq_timer2_match_b,
   input wire logic irq_timer3_match_a,
   input wire logic irq_timer3_match_b,
   input wire logic rst_power_on_clear,
   input wire logic rst_low_voltage,
   input wire logic rst_watchdog,
   input wire logic break_instruction,
   input wire logic core_int_ack,
   input wire logic core_int_return,
   output logic core_int_req,
   output logic [15:0] core_int_vector,
   output logic core_reset_req,
   output logic standby_release,
   output logic irq
);
   // ==========================================================
   // reset release
   logic rst_meta_ff, rst_n_ff;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end
   // ==========================================================
   // declarations
   bus_state_t state_ff, nxt_state;
   logic wait_ff, nxt_wait;
   logic [31:0] rdata_ff, nxt_rdata, rd_word, wmask, wbits;
   logic [16:0] mask_ff, nxt_mask, prio_ff, nxt_prio;
   logic [7:0] rise_ff, nxt_rise, fall_ff, nxt_fall;
   logic ie_ff, nxt_ie;
   logic [16:0] flags_ff, nxt_flags, set_vec, clr_vec, pending;
   logic [16:0] hi_cand, lo_cand;
   logic [5:0] hi_pick, lo_pick;
   logic swi_ff, nxt_swi, isv_hi_ff, nxt_isv_hi, isv_lo_ff, nxt_isv_lo;
   logic req_ff, nxt_req, sel_swi_ff, nxt_sel_swi, sel_hi_ff, nxt_sel_hi;
   logic [4:0] sel_slot_ff, nxt_sel_slot;
   logic [15:0] vector_ff, nxt_vector;
   logic [2:0] cause_ff, nxt_cause;
   logic rst_ff, nxt_rst, intr_ff, nxt_intr, stby_ff, nxt_stby;
   logic wr_fire, ack_take, rst_req;
   pin_edge_if pins_if ();
   // ==========================================================
   // pin edge detection
   pin_edge_detect u_pins (
      .sys_clk(sys_clk),
      .rst_n(rst_n_ff),
      .clk_en(clk_en),
      .pin_in(ext_pin_in),
      .port(pins_if.detector)
   );
   assign pins_if.rise_en = rise_ff;
   assign pins_if.fall_en = fall_ff;
   // ==========================================================
   // avalon slave, one wait state per access
   assign wr_fire = (state_ff == BUS_ANSWER) && avs_write;
   assign wmask = be_mask(avs_byteenable);
   assign wbits = avs_writedata & wmask;
   // read mux, unmapped offsets read zero
   always_comb begin
      rd_word = 32'h0000_0000;
      case (avs_address)
         REG_FLAGS: rd_word[16:0] = flags_ff;
         REG_MASK: rd_word[16:0] = mask_ff;
         REG_PRIO: rd_word[16:0] = prio_ff;
         REG_CTRL: rd_word[CTRL_IE] = ie_ff;
         REG_STATUS: begin
            rd_word[STAT_ISV_LO] = isv_lo_ff;
            rd_word[STAT_ISV_HI] = isv_hi_ff;
            rd_word[STAT_REQ] = req_ff;
            rd_word[STAT_SWI] = swi_ff;
            rd_word[STAT_VEC_LSB +: 16] = vector_ff;
         end
         REG_CAUSE: rd_word[2:0] = cause_ff;
         REG_PIN_RISE: rd_word[7:0] = rise_ff;
         REG_PIN_FALL: rd_word[7:0] = fall_ff;
         default: rd_word = 32'h0000_0000;
      endcase
   end
   // bus sequencing
   always_comb begin
      nxt_state = state_ff;
      nxt_wait = wait_ff;
      nxt_rdata = rdata_ff;
      unique case (state_ff)
         BUS_IDLE: begin
            if (avs_read || avs_write) begin
               nxt_state = BUS_ANSWER;
               nxt_wait = 1'b0;
               nxt_rdata = avs_read ? rd_word : 32'h0000_0000;
            end
         end
         BUS_ANSWER: begin
            nxt_state = BUS_IDLE;
            nxt_wait = 1'b1;
         end
      endcase
   end
   always_ff @(posedge sys_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         state_ff <= BUS_IDLE;
         wait_ff <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else if (clk_en) begin
         state_ff <= nxt_state;
         wait_ff <= nxt_wait;
         rdata_ff <= nxt_rdata;
      end
   end
   assign avs_readdata = rdata_ff;
   assign avs_waitrequest = wait_ff;
   // ==========================================================
   // configuration registers, byte lane writes
   always_comb begin
      nxt_mask = mask_ff;
      nxt_prio = prio_ff;
      nxt_ie = ie_ff;
      nxt_rise = rise_ff;
      nxt_fall = fall_ff;
      if (wr_fire && avs_address == REG_MASK) begin
         nxt_mask = (mask_ff & ~wmask[16:0]) | wbits[16:0];
      end
      if (wr_fire && avs_address == REG_PRIO) begin
         nxt_prio = (prio_ff & ~wmask[16:0]) | wbits[16:0];
      end
      if (wr_fire && avs_address == REG_CTRL && wmask[CTRL_IE]) begin
         nxt_ie = avs_writedata[CTRL_IE];
      end
      if (wr_fire && avs_address == REG_PIN_RISE) begin
         nxt_rise = (rise_ff & ~wmask[7:0]) | wbits[7:0];
      end
      if (wr_fire && avs_address == REG_PIN_FALL) begin
         nxt_fall = (fall_ff & ~wmask[7:0]) | wbits[7:0];
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         mask_ff <= MASK_RST;
         prio_ff <= PRIO_RST;
         ie_ff <= 1'b0;
         rise_ff <= RISE_RST;
         fall_ff <= FALL_RST;
      end else if (clk_en) begin
         mask_ff <= nxt_mask;
         prio_ff <= nxt_prio;
         ie_ff <= nxt_ie;
         rise_ff <= nxt_rise;
         fall_ff <= nxt_fall;
      end
   end
   // ==========================================================
   // source collection onto priority slots
   always_comb begin
      set_vec = 17'h00000;
      set_vec[SLOT_LVI] = irq_low_voltage;
      for (int i = 0; i < 6; i++) begin
         set_vec[SLOT_PIN0 + i] = pins_if.edge_hit[i];
      end
      set_vec[SLOT_TM2A] = set_vec[SLOT_TM2A] | irq_timer2_match_a;
      set_vec[SLOT_TM2B] = set_vec[SLOT_TM2B] | irq_timer2_match_b;
      set_vec[SLOT_TM3A] = set_vec[SLOT_TM3A] | irq_timer3_match_a;
      set_vec[SLOT_TM3B] = set_vec[SLOT_TM3B] | irq_timer3_match_b;
      set_vec[SLOT_CAN_ERR] = irq_can_error;
      set_vec[SLOT_CAN_WAKE] = irq_can_wakeup;
      set_vec[SLOT_CAN_RX] = irq_can_receive;
      set_vec[SLOT_CAN_TX] = irq_can_transmit;
      set_vec[SLOT_SER_A_RXERR] = irq_serial_a_rx_error;
      set_vec[SLOT_SER_A_RXEND] = irq_serial_a_rx_end;
      set_vec[SLOT_SER_A_TXEND] = irq_serial_a_tx_end;
      set_vec[SLOT_CSI] = irq_clocked_serial_end |
         irq_serial_b_rx_error;
      set_vec[SLOT_PIN6] = pins_if.edge_hit[6] | irq_serial_b_rx_end;
      set_vec[SLOT_PIN7] = pins_if.edge_hit[7] | irq_serial_b_tx_end;
   end
   // ==========================================================
   // arbitration: masking, groups, nesting, fixed order
   assign pending = flags_ff & ~mask_ff;
   assign hi_cand = pending & ~prio_ff & {17{~isv_hi_ff}};
   assign lo_cand = pending & prio_ff & {17{~(isv_hi_ff | isv_lo_ff)}};
   assign hi_pick = first_set(hi_cand);
   assign lo_pick = first_set(lo_cand);
   assign ack_take = core_int_ack && req_ff;
   assign rst_req = rst_power_on_clear | rst_low_voltage | rst_watchdog;
   // flags, service levels, request and vector
   always_comb begin
      clr_vec = 17'h00000;
      if (wr_fire && avs_address == REG_FLAGS) begin
         clr_vec = wbits[16:0];
      end
      if (ack_take && !sel_swi_ff) begin
         clr_vec[sel_slot_ff] = 1'b1;
      end
      nxt_flags = (flags_ff & ~clr_vec) | set_vec; // set wins over clear
      nxt_swi = (swi_ff & ~(ack_take & sel_swi_ff)) | break_instruction;
      nxt_isv_hi = isv_hi_ff;
      nxt_isv_lo = isv_lo_ff;
      if (core_int_return) begin
         if (isv_hi_ff) begin
            nxt_isv_hi = 1'b0;
         end else begin
            nxt_isv_lo = 1'b0;
         end
      end
      if (ack_take && !sel_swi_ff) begin
         if (sel_hi_ff) begin
            nxt_isv_hi = 1'b1;
         end else begin
            nxt_isv_lo = 1'b1;
         end
      end
      nxt_req = 1'b0;
      nxt_sel_swi = sel_swi_ff;
      nxt_sel_hi = sel_hi_ff;
      nxt_sel_slot = sel_slot_ff;
      nxt_vector = vector_ff;
      if (!ack_take) begin
         if (swi_ff) begin
            nxt_req = 1'b1;
            nxt_sel_swi = 1'b1;
            nxt_vector = VEC_BREAK;
         end else if (ie_ff && hi_pick[5]) begin
            nxt_req = 1'b1;
            nxt_sel_swi = 1'b0;
            nxt_sel_hi = 1'b1;
            nxt_sel_slot = hi_pick[4:0];
            nxt_vector = vector_of(hi_pick[4:0]);
         end else if (ie_ff && lo_pick[5]) begin
            nxt_req = 1'b1;
            nxt_sel_swi = 1'b0;
            nxt_sel_hi = 1'b0;
            nxt_sel_slot = lo_pick[4:0];
            nxt_vector = vector_of(lo_pick[4:0]);
         end
      end
      nxt_cause = cause_ff;
      if (wr_fire && avs_address == REG_CAUSE) begin
         nxt_cause = cause_ff & ~wbits[2:0];
      end
      nxt_cause = nxt_cause |
         {rst_watchdog, rst_low_voltage, rst_power_on_clear};
      nxt_rst = rst_req;
      if (rst_req) begin
         nxt_flags = 17'h00000;
         nxt_swi = 1'b0;
         nxt_isv_hi = 1'b0;
         nxt_isv_lo = 1'b0;
         nxt_req = 1'b0;
         nxt_vector = VEC_RESET;
      end
      nxt_intr = |pending;
      nxt_stby = (|pending) | swi_ff;
   end
   always_ff @(posedge sys_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         flags_ff <= 17'h00000;
         swi_ff <= 1'b0;
         isv_hi_ff <= 1'b0;
         isv_lo_ff <= 1'b0;
         req_ff <= 1'b0;
         sel_swi_ff <= 1'b0;
         sel_hi_ff <= 1'b0;
         sel_slot_ff <= 5'h00;
         vector_ff <= VEC_RESET;
         cause_ff <= 3'h0;
         rst_ff <= 1'b0;
         intr_ff <= 1'b0;
         stby_ff <= 1'b0;
      end else if (clk_en) begin
         flags_ff <= nxt_flags;
         swi_ff <= nxt_swi;
         isv_hi_ff <= nxt_isv_hi;
         isv_lo_ff <= nxt_isv_lo;
         req_ff <= nxt_req;
         sel_swi_ff <= nxt_sel_swi;
         sel_hi_ff <= nxt_sel_hi;
         sel_slot_ff <= nxt_sel_slot;
         vector_ff <= nxt_vector;
         cause_ff <= nxt_cause;
         rst_ff <= nxt_rst;
         intr_ff <= nxt_intr;
         stby_ff <= nxt_stby;
      end
   end
   assign core_int_req = req_ff;
   assign core_int_vector = vector_ff;
   assign core_reset_req = rst_ff;
   assign standby_release = stby_ff;
   assign irq = intr_ff;
   // ==========================================================
   // assertions
   logic [16:0] pend_d_ff, hi_d_ff, lo_d_ff;
   always_ff @(posedge sys_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         pend_d_ff <= 17'h00000;
         hi_d_ff <= 17'h00000;
         lo_d_ff <= 17'h00000;
      end else if (clk_en) begin
         pend_d_ff <= pending;
         hi_d_ff <= hi_cand;
         lo_d_ff <= lo_cand;
      end
   end
   default clocking cb @(posedge sys_clk iff clk_en);
   endclocking
   default disable iff (!rst_n_ff);
   property p_masked_held;
      (req_ff && !sel_swi_ff) |-> pend_d_ff[sel_slot_ff];
   endproperty
   a_masked_held: assert property (p_masked_held)
      else $error("request for a masked or idle slot");
   property p_tie_order;
      (req_ff && !sel_swi_ff) |->
         ((sel_hi_ff ? hi_d_ff : lo_d_ff) &
         ((17'h00001 << sel_slot_ff) - 17'h00001)) == 17'h00000;
   endproperty
   a_tie_order: assert property (p_tie_order)
      else $error("stronger slot of the same group passed over");
   property p_group_rank;
      (req_ff && !sel_swi_ff && !sel_hi_ff) |-> hi_d_ff == 17'h00000;
   endproperty
   a_group_rank: assert property (p_group_rank)
      else $error("low group chosen over a high candidate");
   property p_nest;
      (isv_lo_ff && hi_cand != 17'h00000 && ie_ff && !swi_ff &&
         !ack_take && !rst_req) |=> (req_ff && sel_hi_ff && !sel_swi_ff);
   endproperty
   a_nest: assert property (p_nest)
      else $error("high request not raised during low service");
   property p_standby;
      (pending != 17'h00000) |=> stby_ff;
   endproperty
   a_standby: assert property (p_standby)
      else $error("standby release missing for pending request");
   property p_break_taken;
      (swi_ff && !ack_take && !rst_req) |=>
         (req_ff && sel_swi_ff && vector_ff == VEC_BREAK);
   endproperty
   a_break_taken: assert property (p_break_taken)
      else $error("break interrupt not requested at its vector");
   property p_break_bypass;
      (ack_take && sel_swi_ff && !core_int_return && !rst_req) |=>
         (isv_hi_ff == $past(isv_hi_ff) && isv_lo_ff == $past(isv_lo_ff));
   endproperty
   a_break_bypass: assert property (p_break_bypass)
      else $error("break acceptance changed service levels");
   property p_vector;
      (req_ff && !sel_swi_ff) |-> vector_ff == vector_of(sel_slot_ff);
   endproperty
   a_vector: assert property (p_vector)
      else $error("vector does not match slot");
   property p_merge;
      (irq_serial_b_rx_end && !rst_req) |=> flags_ff[SLOT_SER_B_RXEND];
   endproperty
   a_merge: assert property (p_merge)
      else $error("merged source did not set its slot flag");
   property p_reset_src;
      rst_watchdog |=> (cause_ff[2] && flags_ff == 17'h00000 && rst_ff);
   endproperty
   a_reset_src: assert property (p_reset_src)
      else $error("reset source not recorded or state not cleared");
   c_nested: cover property (isv_lo_ff && isv_hi_ff);
   c_break_ack: cover property (ack_take && sel_swi_ff);
   c_low_ack: cover property (ack_take && !sel_swi_ff && !sel_hi_ff);
   c_bus_write: cover property (wr_fire && avs_address == REG_MASK);
endmodule // vectored_interrupt_priority

// ===== core_model.sv
// behavioural processor core that acknowledges offered vectored interrupts
`timescale 1ns/1ns
module core_model (
   input wire logic sys_clk,
   input wire logic stall,
   input wire logic core_int_req,
   input wire logic [15:0] core_int_vector,
   output logic core_int_ack,
   output logic [15:0] last_vec,
   output logic [7:0] acks
);
   initial begin
      core_int_ack = 1'b0;
      last_vec = 16'h0000;
      acks = 8'h00;
   end
   // raise ack while a request shows, held off by stall
   // the vector is taken at the edge that samples ack, since it may change
   always @(posedge sys_clk) begin
      if (core_int_ack) begin
         core_int_ack <= 1'b0;
         if (core_int_req) begin
            last_vec <= core_int_vector;
            acks <= acks + 8'h01;
         end
      end else if (core_int_req && !stall) begin
         core_int_ack <= 1'b1;
      end
   end
endmodule // core_model

// ===== tb.sv
// self-checking testbench of the vectored interrupt controller
`timescale 1ns/1ns
module tb;
   import intc_pkg::*;
   logic sys_clk = 1'b0, resetn = 1'b0, rd_s = 1'b0, wr_s = 1'b0;
   logic ret_s = 1'b0, stall = 1'b0, ack, req, rst_req, stby, irq;
   logic [5:0] addr = 6'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [19:0] ev = 20'h0; // 15:0 sources, 16 break, 19:17 resets
   logic [7:0] pins = 8'h00, acks, resets = 8'h00;
   logic [15:0] vec, last_vec;
   logic wreq;
   int miscompares = 0, checks = 0;
   int slot_tab[16] = '{0, 7, 8, 9, 10, 11, 12, 13, 14, 14, 15, 16, 3, 4, 5, 6};
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (rst_req === 1'b1) resets <= resets + 8'h01;
   vectored_interrupt_priority dut (.sys_clk(sys_clk), .resetn(resetn),
      .clk_en(1'b1), .avs_address(addr), .avs_read(rd_s), .avs_write(wr_s),
      .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat),
      .avs_waitrequest(wreq), .irq_low_voltage(ev[0]), .ext_pin_in(pins),
      .irq_can_error(ev[1]), .irq_can_wakeup(ev[2]), .irq_can_receive(ev[3]),
      .irq_can_transmit(ev[4]), .irq_serial_a_rx_error(ev[5]),
      .irq_serial_a_rx_end(ev[6]), .irq_serial_a_tx_end(ev[7]),
      .irq_clocked_serial_end(ev[8]), .irq_serial_b_rx_error(ev[9]),
      .irq_serial_b_rx_end(ev[10]), .irq_serial_b_tx_end(ev[11]),
      .irq_timer2_match_a(ev[12]), .irq_timer2_match_b(ev[13]),
      .irq_timer3_match_a(ev[14]), .irq_timer3_match_b(ev[15]),
      .break_instruction(ev[16]), .rst_power_on_clear(ev[17]),
      .rst_low_voltage(ev[18]), .rst_watchdog(ev[19]), .core_int_ack(ack),
      .core_int_return(ret_s), .core_int_req(req), .core_int_vector(vec),
      .core_reset_req(rst_req), .standby_release(stby), .irq(irq));
   core_model core (.sys_clk(sys_clk), .stall(stall), .core_int_req(req),
      .core_int_vector(vec), .core_int_ack(ack), .last_vec(last_vec),
      .acks(acks));
   // compare and count
   task automatic chk(input string n, input logic [31:0] s, e);
      checks++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // one avalon access, held until waitrequest is seen low
   task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdat <= d;
      rd_s <= !w;
      wr_s <= w;
      do @(posedge sys_clk); while (wreq !== 1'b0);
      q = rdat;
      rd_s <= 1'b0;
      wr_s <= 1'b0;
   endtask
   task automatic pulse(input logic [19:0] m);
      @(posedge sys_clk);
      ev <= m;
      @(posedge sys_clk);
      ev <= 20'h0;
   endtask
   task automatic ret();
      @(posedge sys_clk);
      ret_s <= 1'b1;
      @(posedge sys_clk);
      ret_s <= 1'b0;
   endtask
   // wait for the core to take a vector, then compare it
   task automatic take(input logic [15:0] e);
      logic [7:0] a0;
      a0 = acks;
      for (int i = 0; i < 50 && acks === a0; i++) @(negedge sys_clk);
      chk("acked", {24'h0, acks}, {24'h0, a0 + 8'h01});
      chk("vector", {16'h0, last_vec}, {16'h0, e});
   endtask
   task automatic stop_test();
      if (miscompares == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      stop_test();
   end
   initial begin
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      acc(0, REG_MASK, 0); chk("mask", q, 32'h1ffff);
      acc(0, REG_PRIO, 0); chk("prio", q, 32'h1ffff);
      acc(0, 6'h20, 0); chk("unmapped", q, 0);
      // masked request is held back but flagged
      acc(1, REG_CTRL, 1);
      pulse(20'h2);
      repeat (6) @(negedge sys_clk);
      chk("req masked", {31'h0, req}, 0);
      chk("irq masked", {31'h0, irq}, 0);
      acc(0, REG_FLAGS, 0); chk("flags", q, 32'h80);
      stall <= 1'b1;
      acc(1, REG_MASK, 0);
      repeat (3) @(negedge sys_clk);
      chk("irq", {31'h0, irq}, 1);
      chk("standby", {31'h0, stby}, 1);
      stall <= 1'b0;
      take(16'h0012);
      ret();
      // every non-pin source on its own slot vector
      for (int i = 0; i < 16; i++) begin
         pulse(20'h1 << i);
         take(16'h0004 + 16'(2 * slot_tab[i]));
         ret();
      end
      // pins 0 and 7 on rising edges
      pins <= 8'h01;
      take(16'h0006);
      ret();
      pins <= 8'h81;
      take(16'h0024);
      ret();
      // pin 0 on a falling edge once enabled
      acc(1, REG_PIN_FALL, 32'h01);
      pins <= 8'h80;
      take(16'h0006);
      ret();
      // same group tie, then high group first
      for (int g = 0; g < 2; g++) begin
         stall <= 1'b1;
         acc(1, REG_PRIO, g ? 32'h1efff : 32'h1ffff);
         pulse(20'h48);
         stall <= 1'b0;
         take(g ? 16'h001c : 16'h0016);
         ret();
         take(g ? 16'h0016 : 16'h001c);
         ret();
      end
      // low service nested by high, then break with all levels busy
      pulse(20'h8);
      take(16'h0016);
      pulse(20'h40);
      take(16'h001c);
      acc(0, REG_STATUS, 0); chk("status", q, 32'h001c0003);
      acc(1, REG_CTRL, 0);
      pulse(20'h10000);
      take(VEC_BREAK);
      acc(0, REG_STATUS, 0); chk("break status", q, 32'h003e0003);
      ret();
      ret();
      // reset sources request a core reset and log their cause
      for (int i = 0; i < 3; i++) begin
         pulse(20'h20000 << i);
         acc(0, REG_CAUSE, 0); chk("cause", q, 32'h1 << i);
         acc(1, REG_CAUSE, 7);
      end
      chk("resets", {24'h0, resets}, 3);
      stop_test();
   end
endmodule // tb
